// File: verilog/xid_pkg.sv
package xid_pkg;

  // Opcode bytes
  localparam logic [7:0] OPC_ESCAPE = 8'h0F;
  localparam logic [7:0] OPC2_MOVE_IF_OVERFLOW = 8'h40;
  localparam logic [7:0] OPC2_MOVE_IF_NO_OVERFLOW = 8'h41;
  localparam logic [7:0] OPC2_MOVE_IF_NEGATIVE = 8'h48;
  localparam logic [7:0] OPC2_MOVE_IF_NOT_NEGATIVE = 8'h49;
  localparam logic [7:0] OPC2_MOVE_IF_PARITY = 8'h4A;
  localparam logic [7:0] OPC2_MOVE_IF_NO_PARITY = 8'h4B;
  localparam logic [7:0] OPC2_SWAP8 = 8'hC7;
  localparam logic [7:0] OPC2_IDENTIFY = 8'hA2;
  localparam logic [7:0] OPC2_SPR_READ = 8'h3C;
  localparam logic [7:0] OPC2_SPR_WRITE = 8'h3D;
  localparam logic [7:0] OPC_SEXT_PAIR = 8'h99;
  localparam logic [7:0] OPC_SEXT_ACCUM = 8'h98;
  localparam logic [7:0] OPC_ADJUST_ADD = 8'h27;
  localparam logic [7:0] OPC_ADJUST_SUB = 8'h2F;

  // Opcode patterns with low flag bits stripped
  localparam logic [5:0] PAT_COMPARE_REG = 6'h0E;
  localparam logic [6:0] PAT_COMPARE_ACC = 7'h1E;
  localparam logic [5:0] PAT_COMPARE_IMM = 6'h20;
  localparam logic [6:0] PAT_DECREMENT = 7'h7F;
  localparam logic [6:0] PAT2_SWAP = 7'h58;

  // ModRM fields
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [2:0] EXT_COMPARE = 3'h7;
  localparam logic [2:0] EXT_DECREMENT = 3'h1;
  localparam logic [2:0] EXT_SWAP8 = 3'h1;

  // Flag vector layout, one bit per flag
  localparam int FLG_CARRY = 0;
  localparam int FLG_PARITY = 1;
  localparam int FLG_AUX = 2;
  localparam int FLG_ZERO = 3;
  localparam int FLG_SIGN = 4;
  localparam int FLG_TRAP = 5;
  localparam int FLG_INTR = 6;
  localparam int FLG_DIR = 7;
  localparam int FLG_OVERFLOW = 8;
  localparam logic [8:0] FMASK_NONE = 9'h000;
  localparam logic [8:0] FMASK_ADJUST = (9'h001 << FLG_SIGN) |
    (9'h001 << FLG_ZERO) | (9'h001 << FLG_AUX) |
    (9'h001 << FLG_PARITY) | (9'h001 << FLG_CARRY);
  localparam logic [8:0] FMASK_ARITH = FMASK_ADJUST |
    (9'h001 << FLG_OVERFLOW);
  localparam logic [8:0] FMASK_DECREMENT = FMASK_ARITH &
    ~(9'h001 << FLG_CARRY);

  // Execution clocks on a cache hit
  localparam logic [3:0] CYC_MOVE = 4'h1;
  localparam logic [3:0] CYC_COMPARE = 4'h1;
  localparam logic [3:0] CYC_SWAP = 4'h6;
  localparam logic [3:0] CYC_SWAP8 = 4'h1;
  localparam logic [3:0] CYC_IDENTIFY = 4'hC;
  localparam logic [3:0] CYC_SPR = 4'h1;
  localparam logic [3:0] CYC_SEXT_PAIR = 4'h2;
  localparam logic [3:0] CYC_SEXT_ACCUM = 4'h3;
  localparam logic [3:0] CYC_ADJUST = 4'h2;
  localparam logic [3:0] CYC_DECREMENT = 4'h1;
  localparam logic [3:0] CYC_UNSUPPORTED = 4'h1;

  // Lengths in bytes
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_FOUR = 3'h4;
  localparam logic [2:0] LEN_NONE = 3'h0;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_MOVE_IF_OVERFLOW = 5'h01,
    OP_MOVE_IF_NO_OVERFLOW = 5'h02,
    OP_MOVE_IF_NEGATIVE = 5'h03,
    OP_MOVE_IF_NOT_NEGATIVE = 5'h04,
    OP_MOVE_IF_PARITY = 5'h05,
    OP_MOVE_IF_NO_PARITY = 5'h06,
    OP_COMPARE_REG_REG = 5'h07,
    OP_COMPARE_REG_TO_MEM = 5'h08,
    OP_COMPARE_MEM_TO_REG = 5'h09,
    OP_COMPARE_IMM = 5'h0A,
    OP_COMPARE_IMM_ACC = 5'h0B,
    OP_COMPARE_AND_SWAP = 5'h0C,
    OP_COMPARE_AND_SWAP_EIGHT_BYTE = 5'h0D,
    OP_PROCESSOR_IDENTIFY = 5'h0E,
    OP_SPR_READ = 5'h0F,
    OP_SPR_WRITE = 5'h10,
    OP_WORD_SIGN_EXTEND_PAIR = 5'h11,
    OP_WORD_SIGN_EXTEND_ACCUM = 5'h12,
    OP_DECIMAL_ADJUST_ADD = 5'h13,
    OP_DECIMAL_ADJUST_SUB = 5'h14,
    OP_DECREMENT_ONE = 5'h15,
    OP_UNSUPPORTED = 5'h16
  } xid_op_t;

  typedef enum logic [1:0] {
    W_BYTE = 2'h0,
    W_WORD = 2'h1,
    W_DWORD = 2'h2
  } xid_width_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_EXEC = 2'h2
  } xid_state_t;

  typedef struct packed {
    xid_state_t state;
    logic [3:0] remain;
    logic ready;
    logic op_valid;
    logic done;
    xid_op_t op;
    xid_width_t width;
    logic [7:0] modrm;
    logic mem;
    logic dir;
    logic sext;
    logic [2:0] imm_len;
    logic [2:0] insn_len;
    logic [8:0] mask;
    logic [3:0] cycles;
    logic write;
    logic unsup;
  } xid_regs_t;

  localparam xid_regs_t REGS_RESET = '{
    state: ST_IDLE, remain: 4'h0, ready: 1'b1, op_valid: 1'b0,
    done: 1'b0, op: OP_NONE, width: W_BYTE, modrm: 8'h00, mem: 1'b0,
    dir: 1'b0, sext: 1'b0, imm_len: 3'h0, insn_len: 3'h0,
    mask: 9'h000, cycles: 4'h0, write: 1'b0, unsup: 1'b0};

endpackage : xid_pkg

// File: verilog/xid_cond_eval.sv
`timescale 1ns/100ps
module xid_cond_eval import xid_pkg::*; (
  input wire logic [3:0] cc_i,
  input wire logic [8:0] flags_i,
  output logic hit_o
);

  always_comb begin
    unique case (cc_i)
      OPC2_MOVE_IF_OVERFLOW[3:0]: hit_o = flags_i[FLG_OVERFLOW];
      OPC2_MOVE_IF_NO_OVERFLOW[3:0]: hit_o = ~flags_i[FLG_OVERFLOW];
      OPC2_MOVE_IF_NEGATIVE[3:0]: hit_o = flags_i[FLG_SIGN];
      OPC2_MOVE_IF_NOT_NEGATIVE[3:0]: hit_o = ~flags_i[FLG_SIGN];
      OPC2_MOVE_IF_PARITY[3:0]: hit_o = flags_i[FLG_PARITY];
      OPC2_MOVE_IF_NO_PARITY[3:0]: hit_o = ~flags_i[FLG_PARITY];
      // Codes this slice does not decode never move
      default: hit_o = 1'b0;
    endcase
  end

endmodule : xid_cond_eval

// File: verilog/xid_width_sel.sv
`timescale 1ns/100ps
module xid_width_sel import xid_pkg::*; (
  input wire logic w_bit_i,
  input wire logic wide_only_i,
  input wire logic opsize32_i,
  output xid_width_t width_o
);

  always_comb begin
    if (!w_bit_i && !wide_only_i) begin
      width_o = W_BYTE;
    end else if (opsize32_i) begin
      width_o = W_DWORD;
    end else begin
      width_o = W_WORD;
    end
  end

endmodule : xid_width_sel

// File: verilog/xid_decode.sv
// Summary of operation
// RULE1: 0F 41 moves when overflow clear, 1 clock
// RULE2: 0F 4A moves when parity set, 1 clock
// RULE3: 0F 48/49 move on sign set/clear
// RULE4: compare register form, mod 11, 1 clock
// RULE5: compare updates six arithmetic flags only
// RULE6: compare immediate, 80-83 with reg 111
// RULE7: compare immediate with accumulator, 3C/3D
// RULE8: compare-and-swap 0F B0/B1, 6 clocks
// RULE9: eight-byte swap is 0F C7 reg 001
// RULE10: identify 0F A2, 12 clocks, no flags
// RULE11: special register read 0F 3C, 1 clock
// RULE12: special register write 0F 3D, 1 clock
// RULE13: opcode 99 pair extend, 2 clocks
// RULE14: opcode 98 accumulator extend, 3 clocks
// RULE15: opcode 27 adjust after add, 2 clocks
// RULE16: opcode 2F adjust after subtract, 2 clocks
// RULE17: FE/FF reg 001 decrement, carry kept
// RULE18: 0F 40 moves when overflow set
// RULE19: conditional move writes only when condition holds
// RULE20: w bit picks byte or full size
`timescale 1ns/100ps
module xid_decode import xid_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic insn_valid_i,
  input wire logic [7:0] opc_byte0_i,
  input wire logic [7:0] opc_byte1_i,
  input wire logic [7:0] opc_byte2_i,
  input wire logic opsize32_i,
  input wire logic [8:0] flags_i,
  output logic insn_ready_o,
  output logic op_valid_o,
  output logic op_done_o,
  output xid_op_t op_kind_o,
  output xid_width_t op_width_o,
  output logic [7:0] modrm_o,
  output logic mem_operand_o,
  output logic dir_bit_o,
  output logic imm_sext_o,
  output logic [2:0] imm_len_o,
  output logic [2:0] insn_len_o,
  output logic [8:0] flag_update_o,
  output logic [3:0] cycles_o,
  output logic dest_write_o,
  output logic unsupported_o
);

  xid_regs_t r_reg;
  xid_regs_t r_next;

  xid_op_t d_op;
  logic d_wbit;
  logic d_wide_only;
  logic d_has_modrm;
  logic [7:0] d_modrm;
  logic d_has_imm;
  logic d_dir;
  logic d_sext;
  logic d_escape;
  logic [8:0] d_mask;
  logic [3:0] d_cyc;
  logic d_write;
  logic d_is_move;
  logic d_unsup;
  logic cond_hit;
  xid_width_t d_width;
  logic [2:0] d_imm_len;
  logic [2:0] d_insn_len;

  xid_cond_eval u_cond (
    .cc_i(opc_byte1_i[3:0]),
    .flags_i(flags_i),
    .hit_o(cond_hit)
  );

  xid_width_sel u_width (
    .w_bit_i(d_wbit),
    .wide_only_i(d_wide_only),
    .opsize32_i(opsize32_i),
    .width_o(d_width)
  );

  always_comb begin
    d_op = OP_UNSUPPORTED;
    d_wbit = 1'b0;
    d_wide_only = 1'b0;
    d_has_modrm = 1'b0;
    d_modrm = opc_byte1_i;
    d_has_imm = 1'b0;
    d_dir = 1'b0;
    d_sext = 1'b0;
    d_escape = 1'b0;
    d_mask = FMASK_NONE;
    d_cyc = CYC_UNSUPPORTED;
    d_write = 1'b0;
    d_is_move = 1'b0;
    d_unsup = 1'b1;
    if (opc_byte0_i == OPC_ESCAPE) begin
      d_escape = 1'b1;
      d_modrm = opc_byte2_i;
      if (opc_byte1_i == OPC2_MOVE_IF_NO_OVERFLOW) begin
        // RULE1: overflow-clear move
        d_op = OP_MOVE_IF_NO_OVERFLOW;
        d_is_move = 1'b1;
      end else if (opc_byte1_i == OPC2_MOVE_IF_OVERFLOW) begin
        // RULE18: overflow-set move
        d_op = OP_MOVE_IF_OVERFLOW;
        d_is_move = 1'b1;
      end else if (opc_byte1_i == OPC2_MOVE_IF_PARITY) begin
        // RULE2: parity-even move
        d_op = OP_MOVE_IF_PARITY;
        d_is_move = 1'b1;
      end else if (opc_byte1_i == OPC2_MOVE_IF_NO_PARITY) begin
        d_op = OP_MOVE_IF_NO_PARITY;
        d_is_move = 1'b1;
      end else if (opc_byte1_i == OPC2_MOVE_IF_NEGATIVE) begin
        // RULE3: sign-set move
        d_op = OP_MOVE_IF_NEGATIVE;
        d_is_move = 1'b1;
      end else if (opc_byte1_i == OPC2_MOVE_IF_NOT_NEGATIVE) begin
        // RULE3: sign-clear move
        d_op = OP_MOVE_IF_NOT_NEGATIVE;
        d_is_move = 1'b1;
      end else if (opc_byte1_i[7:1] == PAT2_SWAP) begin
        // RULE8: swap, six clocks
        d_op = OP_COMPARE_AND_SWAP;
        d_wbit = opc_byte1_i[0];
        d_has_modrm = 1'b1;
        d_mask = FMASK_ARITH;
        d_cyc = CYC_SWAP;
        d_unsup = 1'b0;
      end else if (opc_byte1_i == OPC2_SWAP8 &&
                   opc_byte2_i[5:3] == EXT_SWAP8) begin
        // RULE9: reg field extension
        d_op = OP_COMPARE_AND_SWAP_EIGHT_BYTE;
        d_wide_only = 1'b1;
        d_has_modrm = 1'b1;
        d_cyc = CYC_SWAP8;
        d_unsup = 1'b0;
      end else if (opc_byte1_i == OPC2_IDENTIFY) begin
        // RULE10: twelve clocks
        d_op = OP_PROCESSOR_IDENTIFY;
        d_wide_only = 1'b1;
        d_cyc = CYC_IDENTIFY;
        d_write = 1'b1;
        d_unsup = 1'b0;
      end else if (opc_byte1_i == OPC2_SPR_READ) begin
        // RULE11: special read
        d_op = OP_SPR_READ;
        d_wide_only = 1'b1;
        d_cyc = CYC_SPR;
        d_write = 1'b1;
        d_unsup = 1'b0;
      end else if (opc_byte1_i == OPC2_SPR_WRITE) begin
        // RULE12: special write
        d_op = OP_SPR_WRITE;
        d_wide_only = 1'b1;
        d_cyc = CYC_SPR;
        d_unsup = 1'b0;
      end
      if (d_is_move) begin
        // Moves carry no w bit: always full operand size
        d_wide_only = 1'b1;
        d_has_modrm = 1'b1;
        d_cyc = CYC_MOVE;
        d_unsup = 1'b0;
        // RULE19: write gated by condition
        d_write = cond_hit;
      end
    end else if (opc_byte0_i[7:2] == PAT_COMPARE_REG) begin
      // RULE4: register forms
      d_wbit = opc_byte0_i[0];
      d_dir = opc_byte0_i[1];
      d_has_modrm = 1'b1;
      if (opc_byte1_i[7:6] == MOD_REGISTER) begin
        d_op = OP_COMPARE_REG_REG;
      end else if (opc_byte0_i[1]) begin
        d_op = OP_COMPARE_REG_TO_MEM;
      end else begin
        d_op = OP_COMPARE_MEM_TO_REG;
      end
      // RULE5: six arithmetic flags
      d_mask = FMASK_ARITH;
      d_cyc = CYC_COMPARE;
      d_unsup = 1'b0;
    end else if (opc_byte0_i[7:1] == PAT_COMPARE_ACC) begin
      // RULE7: accumulator immediate
      d_op = OP_COMPARE_IMM_ACC;
      d_wbit = opc_byte0_i[0];
      d_has_imm = 1'b1;
      d_mask = FMASK_ARITH;
      d_cyc = CYC_COMPARE;
      d_unsup = 1'b0;
    end else if (opc_byte0_i[7:2] == PAT_COMPARE_IMM &&
                 opc_byte1_i[5:3] == EXT_COMPARE) begin
      // RULE6: immediate with reg 111
      d_op = OP_COMPARE_IMM;
      d_wbit = opc_byte0_i[0];
      d_sext = opc_byte0_i[1];
      d_has_modrm = 1'b1;
      d_has_imm = 1'b1;
      d_mask = FMASK_ARITH;
      d_cyc = CYC_COMPARE;
      d_unsup = 1'b0;
    end else if (opc_byte0_i[7:1] == PAT_DECREMENT &&
                 opc_byte1_i[5:3] == EXT_DECREMENT) begin
      // RULE17: carry preserved
      d_op = OP_DECREMENT_ONE;
      d_wbit = opc_byte0_i[0];
      d_has_modrm = 1'b1;
      d_mask = FMASK_DECREMENT;
      d_cyc = CYC_DECREMENT;
      d_write = 1'b1;
      d_unsup = 1'b0;
    end else if (opc_byte0_i == OPC_SEXT_PAIR) begin
      // RULE13: two clocks
      d_op = OP_WORD_SIGN_EXTEND_PAIR;
      d_wide_only = 1'b1;
      d_cyc = CYC_SEXT_PAIR;
      d_write = 1'b1;
      d_unsup = 1'b0;
    end else if (opc_byte0_i == OPC_SEXT_ACCUM) begin
      // RULE14: three clocks
      d_op = OP_WORD_SIGN_EXTEND_ACCUM;
      d_wide_only = 1'b1;
      d_cyc = CYC_SEXT_ACCUM;
      d_write = 1'b1;
      d_unsup = 1'b0;
    end else if (opc_byte0_i == OPC_ADJUST_ADD) begin
      // RULE15: adjust after add
      d_op = OP_DECIMAL_ADJUST_ADD;
      d_mask = FMASK_ADJUST;
      d_cyc = CYC_ADJUST;
      d_write = 1'b1;
      d_unsup = 1'b0;
    end else if (opc_byte0_i == OPC_ADJUST_SUB) begin
      // RULE16: adjust after subtract
      d_op = OP_DECIMAL_ADJUST_SUB;
      d_mask = FMASK_ADJUST;
      d_cyc = CYC_ADJUST;
      d_write = 1'b1;
      d_unsup = 1'b0;
    end
  end

  // Immediate size; displacement and SIB bytes are not counted here
  always_comb begin
    d_imm_len = LEN_NONE;
    if (d_has_imm) begin
      // RULE20: byte immediate when w clear
      if (!d_wbit || d_sext) begin
        d_imm_len = LEN_ONE;
      end else if (d_width == W_DWORD) begin
        d_imm_len = LEN_FOUR;
      end else begin
        d_imm_len = LEN_TWO;
      end
    end
    d_insn_len = LEN_ONE + {2'h0, d_escape} + {2'h0, d_has_modrm} +
      d_imm_len;
  end

  always_comb begin
    r_next = r_reg;
    r_next.op_valid = 1'b0;
    r_next.done = 1'b0;
    unique case (r_reg.state)
      ST_IDLE: begin
        if (insn_valid_i) begin
          r_next.state = ST_EXEC;
          r_next.ready = 1'b0;
          r_next.op_valid = 1'b1;
          r_next.remain = d_cyc;
          r_next.cycles = d_cyc;
          r_next.op = d_op;
          r_next.width = d_width;
          r_next.modrm = d_has_modrm ? d_modrm : 8'h00;
          r_next.mem = d_has_modrm && (d_modrm[7:6] != MOD_REGISTER);
          r_next.dir = d_dir;
          r_next.sext = d_sext;
          r_next.imm_len = d_imm_len;
          r_next.insn_len = d_insn_len;
          r_next.mask = d_mask;
          r_next.write = d_write;
          r_next.unsup = d_unsup;
        end
      end
      ST_EXEC: begin
        // Hold off the next instruction until the clock count elapses
        if (r_reg.remain == 4'h1) begin
          r_next.state = ST_IDLE;
          r_next.ready = 1'b1;
          r_next.done = 1'b1;
        end else begin
          r_next.remain = r_reg.remain - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign insn_ready_o = r_reg.ready;
  assign op_valid_o = r_reg.op_valid;
  assign op_done_o = r_reg.done;
  assign op_kind_o = r_reg.op;
  assign op_width_o = r_reg.width;
  assign modrm_o = r_reg.modrm;
  assign mem_operand_o = r_reg.mem;
  assign dir_bit_o = r_reg.dir;
  assign imm_sext_o = r_reg.sext;
  assign imm_len_o = r_reg.imm_len;
  assign insn_len_o = r_reg.insn_len;
  assign flag_update_o = r_reg.mask;
  assign cycles_o = r_reg.cycles;
  assign dest_write_o = r_reg.write;
  assign unsupported_o = r_reg.unsup;

endmodule : xid_decode

// File: tb/xid_decode_sva.sv
`timescale 1ns/100ps
module xid_decode_chk import xid_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic insn_valid_i,
  input wire logic [8:0] flags_i,
  input wire logic insn_ready_o,
  input wire logic op_valid_o,
  input wire logic op_done_o,
  input wire xid_op_t op_kind_o,
  input wire xid_width_t op_width_o,
  input wire logic [8:0] flag_update_o,
  input wire logic [3:0] cycles_o,
  input wire logic dest_write_o
);
  logic [3:0] cnt_reg;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Counts from the op_valid_o cycle while busy, so it equals N at done
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_reg <= 4'h0;
    else if (op_valid_o) cnt_reg <= 4'h1;
    else if (!insn_ready_o) cnt_reg <= cnt_reg + 4'h1;
  end
  a_take_answer: assert property (
    insn_valid_i && insn_ready_o |=> op_valid_o && !insn_ready_o)
    else $error("accepted request not answered");
  a_done_count: assert property (
    op_done_o |-> cnt_reg == cycles_o && insn_ready_o)
    else $error("done pulse at wrong count");
  a_move_quick: assert property (
    op_valid_o && op_kind_o inside {[OP_MOVE_IF_OVERFLOW:
    OP_MOVE_IF_NO_PARITY]} |-> flag_update_o == FMASK_NONE ##1 op_done_o)
    else $error("conditional move mask or timing wrong");
  a_cmp_flags: assert property (
    op_valid_o && op_kind_o inside {[OP_COMPARE_REG_REG:OP_COMPARE_IMM_ACC]}
    |-> flag_update_o == FMASK_ARITH && cycles_o == CYC_COMPARE)
    else $error("compare mask or count wrong");
  a_swap_slow: assert property (
    op_valid_o && op_kind_o == OP_COMPARE_AND_SWAP
    |=> !op_done_o [*5] ##1 op_done_o)
    else $error("swap not six clocks");
  a_ident_time: assert property (
    op_valid_o && op_kind_o == OP_PROCESSOR_IDENTIFY
    |-> flag_update_o == FMASK_NONE ##12 op_done_o)
    else $error("identify not twelve clocks");
  a_dec_carry: assert property (
    op_valid_o && op_kind_o == OP_DECREMENT_ONE
    |-> flag_update_o == FMASK_DECREMENT)
    else $error("decrement mask wrong");
  a_adjust_mask: assert property (
    op_valid_o && op_kind_o inside {OP_DECIMAL_ADJUST_ADD,
    OP_DECIMAL_ADJUST_SUB} |-> flag_update_o == FMASK_ADJUST ##2 op_done_o)
    else $error("decimal adjust mask or timing wrong");
  a_sext_time: assert property (
    op_valid_o && op_kind_o == OP_WORD_SIGN_EXTEND_ACCUM
    |-> flag_update_o == FMASK_NONE ##3 op_done_o)
    else $error("accumulator extend timing wrong");
  a_move_write: assert property (
    op_valid_o && op_kind_o == OP_MOVE_IF_NEGATIVE
    |-> dest_write_o == $past(flags_i[FLG_SIGN]))
    else $error("move write not from sampled sign");
  a_move_width: assert property (
    op_valid_o && op_kind_o inside {[OP_MOVE_IF_OVERFLOW:
    OP_MOVE_IF_NO_PARITY]} |-> op_width_o != W_BYTE)
    else $error("conditional move width is byte");
  c_move: cover property (op_valid_o && dest_write_o &&
    op_kind_o == OP_MOVE_IF_PARITY);
  c_ident: cover property (op_valid_o && op_kind_o == OP_PROCESSOR_IDENTIFY);
  c_swap: cover property (op_valid_o && op_kind_o == OP_COMPARE_AND_SWAP);
  c_dec: cover property (op_valid_o && op_kind_o == OP_DECREMENT_ONE);
endmodule : xid_decode_chk

bind xid_decode xid_decode_chk u_chk (.clk_sys_i, .rst_n_i, .insn_valid_i,
  .flags_i, .insn_ready_o, .op_valid_o, .op_done_o, .op_kind_o,
  .op_width_o, .flag_update_o, .cycles_o, .dest_write_o);

// File: tb/xid_fetch_model.sv
`timescale 1ns/100ps
module xid_fetch_model (
  input wire logic clk_i,
  input wire logic insn_ready_i,
  output logic insn_valid_o,
  output logic [7:0] byte0_o,
  output logic [7:0] byte1_o,
  output logic [7:0] byte2_o,
  output logic [8:0] flags_o,
  output logic opsize32_o
);
  initial begin
    insn_valid_o = 1'b0;
    byte0_o = 8'h00;
    byte1_o = 8'h00;
    byte2_o = 8'h00;
    flags_o = 9'h000;
    opsize32_o = 1'b0;
  end
  // After the take, lines are inverted so a late sample decodes wrongly
  task automatic issue(input logic [7:0] a, b, c, input logic [8:0] f,
      input logic s, input int stall);
    int k;
    repeat (stall) @(posedge clk_i);
    insn_valid_o <= 1'b1;
    byte0_o <= a;
    byte1_o <= b;
    byte2_o <= c;
    flags_o <= f;
    opsize32_o <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (insn_ready_i !== 1'b1 && k < 40);
    insn_valid_o <= 1'b0;
    byte0_o <= ~a;
    byte1_o <= ~b;
    byte2_o <= ~c;
    flags_o <= ~f;
    opsize32_o <= ~s;
  endtask : issue
endmodule : xid_fetch_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import xid_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic insn_valid_i, opsize32_i, insn_ready_o, op_valid_o, op_done_o;
  logic dest_write_o, wr, mem_operand_o, dir_bit_o, imm_sext_o;
  logic unsupported_o, mem, dir, sx, uns;
  logic [7:0] modrm_o, mrm;
  logic [7:0] b0, b1, b2;
  logic [8:0] flags_i, flag_update_o, mask;
  logic [3:0] cycles_o, cyc;
  logic [2:0] imm_len_o, ilen, insn_len_o, ln;
  xid_op_t op_kind_o, kind;
  xid_width_t op_width_o, wid;
  int err_total = 0;
  int checks = 0;
  int stall = 0;
  int lat;

  always #4 clk_sys_i = ~clk_sys_i;

  xid_decode dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .insn_valid_i(insn_valid_i), .opc_byte0_i(b0), .opc_byte1_i(b1),
    .opc_byte2_i(b2), .opsize32_i(opsize32_i), .flags_i(flags_i),
    .insn_ready_o(insn_ready_o), .op_valid_o(op_valid_o),
    .op_done_o(op_done_o), .op_kind_o(op_kind_o), .op_width_o(op_width_o),
    .modrm_o(modrm_o), .mem_operand_o(mem_operand_o),
    .dir_bit_o(dir_bit_o), .imm_sext_o(imm_sext_o),
    .imm_len_o(imm_len_o), .insn_len_o(insn_len_o),
    .flag_update_o(flag_update_o),
    .cycles_o(cycles_o), .dest_write_o(dest_write_o),
    .unsupported_o(unsupported_o));

  xid_fetch_model u_fetch (.clk_i(clk_sys_i), .insn_ready_i(insn_ready_o),
    .insn_valid_o(insn_valid_i), .byte0_o(b0), .byte1_o(b1), .byte2_o(b2),
    .flags_o(flags_i), .opsize32_o(opsize32_i));

  task automatic chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // Alternates prompt and stalled requests from the fetch side
  task automatic run_op(input logic [7:0] a, b, c, input logic [8:0] f,
      input logic s);
    int k;
    stall = (stall == 0) ? 2 : 0;
    u_fetch.issue(a, b, c, f, s, stall);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (op_valid_o !== 1'b1 && k < 20);
    if (op_valid_o !== 1'b1) begin
      chk("op_valid_o", 16'h0, 16'h1);
      results;
    end
    kind = op_kind_o;
    wid = op_width_o;
    mask = flag_update_o;
    cyc = cycles_o;
    wr = dest_write_o;
    ilen = imm_len_o;
    mrm = modrm_o;
    mem = mem_operand_o;
    dir = dir_bit_o;
    sx = imm_sext_o;
    ln = insn_len_o;
    uns = unsupported_o;
    lat = 0;
    do begin
      @(posedge clk_sys_i);
      lat++;
    end while (op_done_o !== 1'b1 && lat < 20);
  endtask : run_op

  task automatic exp_op(input logic [7:0] a, b, c, input logic s,
      input xid_op_t k, input xid_width_t w, input logic [8:0] m,
      input logic [3:0] n);
    run_op(a, b, c, 9'h1FF, s);
    chk("op_kind_o", 16'(kind), 16'(k));
    if (k != OP_UNSUPPORTED) chk("op_width_o", 16'(wid), 16'(w));
    chk("flag_update_o", 16'(mask), 16'(m));
    chk("cycles_o", 16'(cyc), 16'(n));
    chk("latency", 16'(lat), 16'(n));
  endtask : exp_op

  task automatic t_moves;
    logic [7:0] op [6] = '{8'h40, 8'h41, 8'h48, 8'h49, 8'h4A, 8'h4B};
    int fb [6] = '{8, 8, 4, 4, 1, 1};
    logic [8:0] f;
    for (int i = 0; i < 6; i++) begin
      for (int v = 0; v < 2; v++) begin
        f = (9'h001 << fb[i]);
        run_op(8'h0F, op[i], 8'hC8, v ? f : ~f, 1'b1);
        chk("op_kind_o", 16'(kind), 16'(OP_MOVE_IF_OVERFLOW + i));
        chk("dest_write_o", 16'(wr), 16'(v ^ (i % 2)));
        chk("flag_update_o", 16'(mask), 16'(FMASK_NONE));
        chk("latency", 16'(lat), 16'h1);
        chk("op_width_o", 16'(wid), 16'(W_DWORD));
      end
    end
  endtask : t_moves

  task automatic t_compare;
    exp_op(8'h38, 8'hC8, 8'h00, 1'b0, OP_COMPARE_REG_REG, W_BYTE,
      FMASK_ARITH, 1);
    chk("mem_operand_o", 16'(mem), 16'h0);
    chk("modrm_o", 16'(mrm), 16'h00C8);
    chk("unsupported_o", 16'(uns), 16'h0);
    chk("insn_len_o", 16'(ln), 16'h2);
    exp_op(8'h3B, 8'hC8, 8'h00, 1'b1, OP_COMPARE_REG_REG, W_DWORD,
      FMASK_ARITH, 1);
    exp_op(8'h39, 8'h00, 8'h00, 1'b0, OP_COMPARE_MEM_TO_REG, W_WORD,
      FMASK_ARITH, 1);
    exp_op(8'h3A, 8'h00, 8'h00, 1'b0, OP_COMPARE_REG_TO_MEM, W_BYTE,
      FMASK_ARITH, 1);
    chk("dir_bit_o", 16'(dir), 16'h1);
    chk("mem_operand_o", 16'(mem), 16'h1);
    exp_op(8'h83, 8'hF8, 8'h00, 1'b1, OP_COMPARE_IMM, W_DWORD,
      FMASK_ARITH, 1);
    chk("imm_len_o", 16'(ilen), 16'h1);
    chk("imm_sext_o", 16'(sx), 16'h1);
    chk("insn_len_o", 16'(ln), 16'h3);
    exp_op(8'h81, 8'hF8, 8'h00, 1'b0, OP_COMPARE_IMM, W_WORD,
      FMASK_ARITH, 1);
    chk("imm_len_o", 16'(ilen), 16'h2);
    exp_op(8'h80, 8'hF0, 8'h00, 1'b0, OP_UNSUPPORTED, W_BYTE,
      FMASK_NONE, 1);
    chk("unsupported_o", 16'(uns), 16'h1);
    exp_op(8'h3C, 8'h05, 8'h00, 1'b0, OP_COMPARE_IMM_ACC, W_BYTE,
      FMASK_ARITH, 1);
    exp_op(8'h3D, 8'h05, 8'h00, 1'b1, OP_COMPARE_IMM_ACC, W_DWORD,
      FMASK_ARITH, 1);
    chk("imm_len_o", 16'(ilen), 16'h4);
    chk("insn_len_o", 16'(ln), 16'h5);
    chk("imm_sext_o", 16'(sx), 16'h0);
  endtask : t_compare

  task automatic t_misc;
    exp_op(8'h0F, 8'hB1, 8'hC8, 1'b1, OP_COMPARE_AND_SWAP, W_DWORD,
      FMASK_ARITH, 6);
    chk("dest_write_o", 16'(wr), 16'h0);
    exp_op(8'h0F, 8'hB0, 8'h08, 1'b0, OP_COMPARE_AND_SWAP, W_BYTE,
      FMASK_ARITH, 6);
    exp_op(8'h0F, 8'hC7, 8'h08, 1'b1, OP_COMPARE_AND_SWAP_EIGHT_BYTE,
      W_DWORD, FMASK_NONE, 1);
    chk("modrm_o", 16'(mrm), 16'h0008);
    chk("insn_len_o", 16'(ln), 16'h3);
    exp_op(8'h0F, 8'hC7, 8'h10, 1'b1, OP_UNSUPPORTED, W_DWORD,
      FMASK_NONE, 1);
    chk("unsupported_o", 16'(uns), 16'h1);
    exp_op(8'h0F, 8'hA2, 8'h00, 1'b0, OP_PROCESSOR_IDENTIFY, W_WORD,
      FMASK_NONE, 12);
    exp_op(8'h0F, 8'h3C, 8'h00, 1'b1, OP_SPR_READ, W_DWORD,
      FMASK_NONE, 1);
    exp_op(8'h0F, 8'h3D, 8'h00, 1'b1, OP_SPR_WRITE, W_DWORD,
      FMASK_NONE, 1);
    exp_op(8'h98, 8'h00, 8'h00, 1'b1, OP_WORD_SIGN_EXTEND_ACCUM, W_DWORD,
      FMASK_NONE, 3);
    exp_op(8'h27, 8'h00, 8'h00, 1'b1, OP_DECIMAL_ADJUST_ADD, W_BYTE,
      FMASK_ADJUST, 2);
    exp_op(8'h2F, 8'h00, 8'h00, 1'b1, OP_DECIMAL_ADJUST_SUB, W_BYTE,
      FMASK_ADJUST, 2);
    exp_op(8'hFE, 8'hC8, 8'h00, 1'b1, OP_DECREMENT_ONE, W_BYTE,
      FMASK_DECREMENT, 1);
    exp_op(8'hFF, 8'h08, 8'h00, 1'b0, OP_DECREMENT_ONE, W_WORD,
      FMASK_DECREMENT, 1);
    exp_op(8'hFF, 8'h10, 8'h00, 1'b0, OP_UNSUPPORTED, W_WORD,
      FMASK_NONE, 1);
  endtask : t_misc

  // Reset lands in the middle of a long identify
  task automatic t_reset;
    u_fetch.issue(8'h0F, 8'hA2, 8'h00, 9'h000, 1'b1, 0);
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("insn_ready_o", 16'(insn_ready_o), 16'h1);
    chk("op_kind_o", 16'(op_kind_o), 16'(OP_NONE));
    rst_n_i <= 1'b1;
    exp_op(8'h99, 8'h00, 8'h00, 1'b0, OP_WORD_SIGN_EXTEND_PAIR, W_WORD,
      FMASK_NONE, 2);
  endtask : t_reset

  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_moves;
    t_compare;
    t_misc;
    t_reset;
    results;
  end
endmodule : tb_top
